//--- core/adct_map.vh
// Register map, field positions and reset values for the second converter control register
`ifndef ADCT_MAP_VH
`define ADCT_MAP_VH
// Byte addresses
`define ADCT_CTRL2_ADR 4'h0
`define ADCT_STAT_ADR 4'h4
`define ADCT_MASK_ADR 4'h8
`define ADCT_CFG_ADR 4'hc
// Control field positions
`define ADCT_REF_HI 15
`define ADCT_REF_LO 13
`define ADCT_SCAN_BIT 10
`define ADCT_CHCNT_HI 9
`define ADCT_CHCNT_LO 8
`define ADCT_BHALF_BIT 7
`define ADCT_CPE_HI 6
`define ADCT_CPE_LO 2
`define ADCT_SPLIT_BIT 1
`define ADCT_ALT_BIT 0
// Configuration register bits
`define ADCT_DMA_BIT 0
`define ADCT_TWELVE_BIT 1
// Status bits
`define ADCT_ST_EVT 0
`define ADCT_ST_DMA 1
// Byte lanes
`define ADCT_LANE_HI 1
`define ADCT_LANE_LO 0
// Counts of channels and event sources
`define ADCT_NUM_CHAN 4
`define ADCT_NUM_EVT 2
// Reset values
`define ADCT_CTRL_RST 16'h0000
`define ADCT_ST_RST 2'h0
`define ADCT_CNT_RST 5'h00
`define ADCT_REF_RST 3'h0
`define ADCT_CHCNT_RST 2'h0
`define ADCT_CHAN_RST 4'h1
// Reference codes
`define ADCT_REF_EXT_HI 3'h1
`define ADCT_REF_EXT_LO 3'h2
`define ADCT_REF_EXT_BOTH 3'h3
`endif

//--- core/adct_evt_count.v
// Conversion counter that pulses after each run of limit_i plus one conversions
`timescale 1ns/10ps
`default_nettype none
`include "adct_map.vh"
module adct_evt_count (
    input wire clk_i,
    input wire rst_i,
    input wire clear_i,
    input wire done_i,
    input wire [4:0] limit_i,
    output wire hit_o,
    output wire [4:0] count_o
);
    reg [4:0] cnt_q;
    reg [4:0] cnt_d;
    // Terminal count reached on this completion
    assign hit_o = done_i && (cnt_q == limit_i);
    assign count_o = cnt_q;
    // Clear beats a completion so the next period is full length
    always @* begin
        cnt_d = cnt_q;
        if (clear_i) begin
            cnt_d = `ADCT_CNT_RST;
        end else if (hit_o) begin
            cnt_d = `ADCT_CNT_RST;
        end else if (done_i) begin
            cnt_d = cnt_q + 5'h01;
        end
    end
    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= `ADCT_CNT_RST;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule
`default_nettype wire

//--- core/adct_ctrl2.v
// Second converter control register with Wishbone slave, event counter and interrupt
//
// Local design decisions: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
`include "adct_map.vh"
module adct_ctrl2 (
    input wire clk_i,
    input wire rst_i,
    // Wishbone classic slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [3:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    output reg err_o,
    // Converter core side
    input wire conv_done_i,
    input wire half_toggle_i,
    output reg ref_ext_high_o,
    output reg ref_ext_low_o,
    output reg scan_first_mux_o,
    output reg [3:0] chan_enable_o,
    output reg buffer_split_mode_o,
    output reg alt_mux_o,
    output reg event_irq_pulse_o,
    output reg dma_step_o,
    output wire irq_o
);
    // ****************************************
    // Register storage
    // ****************************************
    // Control register fields
    reg [2:0] reference_select_q;
    reg input_scan_select_q;
    reg [1:0] channel_count_select_q;
    reg [4:0] conversions_per_event_q;
    reg buffer_split_mode_q;
    reg alt_q;
    reg dma_address_mode_enable_q;
    reg twelve_bit_mode_select_q;
    reg buffer_half_status_q;
    // Status and mask, one bit per event source
    reg [1:0] stat_q;
    reg [1:0] mask_q;
    reg cpe_wr_q;
    wire [15:0] ctrl_rd;
    wire [1:0] channel_count_rd;
    wire [4:0] limit;
    wire hit;
    wire [1:0] evt;
    wire acc;
    wire wr;
    wire map_ok;
    reg [31:0] rd_d;
    // Decode strobes and next values
    wire ctrl_hi_wr;
    wire ctrl_lo_wr;
    wire mask_wr;
    wire cfg_wr;
    wire stat_clr;
    wire [3:0] chan_want;
    wire [1:0] stat_d;

    // ****************************************
    // Bus decode
    // ****************************************
    // One wait state: ack comes the cycle after the request, then drops
    assign acc = cyc_i && stb_i && !ack_o && !err_o;
    assign map_ok = (adr_i == `ADCT_CTRL2_ADR) || (adr_i == `ADCT_STAT_ADR) ||
                    (adr_i == `ADCT_MASK_ADR) || (adr_i == `ADCT_CFG_ADR);
    assign wr = acc && we_i && map_ok;

    // One strobe per register and lane; sel[1] carries bits 15:8, sel[0] bits 7:0
    assign ctrl_hi_wr = wr && (adr_i == `ADCT_CTRL2_ADR) && sel_i[`ADCT_LANE_HI];
    assign ctrl_lo_wr = wr && (adr_i == `ADCT_CTRL2_ADR) && sel_i[`ADCT_LANE_LO];
    assign mask_wr = wr && (adr_i == `ADCT_MASK_ADR) && sel_i[`ADCT_LANE_LO];
    assign cfg_wr = wr && (adr_i == `ADCT_CFG_ADR) && sel_i[`ADCT_LANE_LO];
    assign stat_clr = wr && (adr_i == `ADCT_STAT_ADR) && sel_i[`ADCT_LANE_LO];

    // Channel count hidden in twelve-bit mode
    assign channel_count_rd = twelve_bit_mode_select_q ? 2'h0 : channel_count_select_q;
    assign ctrl_rd = {reference_select_q, 2'h0, input_scan_select_q, channel_count_rd,
                      buffer_half_status_q, conversions_per_event_q,
                      buffer_split_mode_q, alt_q};

    // Read data mux, reserved bits zero
    always @* begin
        rd_d = 32'h0000_0000;
        case (adr_i)
            `ADCT_CTRL2_ADR: begin
                rd_d = {16'h0000, ctrl_rd};
            end
            `ADCT_STAT_ADR: begin
                rd_d = {30'h0000_0000, stat_q};
            end
            `ADCT_MASK_ADR: begin
                rd_d = {30'h0000_0000, mask_q};
            end
            `ADCT_CFG_ADR: begin
                rd_d = {30'h0000_0000, twelve_bit_mode_select_q, dma_address_mode_enable_q};
            end
            default: begin
                rd_d = 32'h0000_0000;
            end
        endcase
    end

    // Answer: ack for mapped, err for unmapped addresses
    // An unmapped read returns zero and an unmapped write changes nothing
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= acc && map_ok;
            err_o <= acc && !map_ok;
            if (acc && !we_i) begin
                dat_o <= rd_d;
            end
        end
    end

    // ****************************************
    // Register writes
    // ****************************************
    // Reference and scan bits sit in the upper byte; a write lands on the taking edge
    always @(posedge clk_i) begin
        if (rst_i) begin
            reference_select_q <= `ADCT_REF_RST;
            input_scan_select_q <= 1'b0;
        end else if (ctrl_hi_wr) begin
            reference_select_q <= dat_i[`ADCT_REF_HI:`ADCT_REF_LO];
            input_scan_select_q <= dat_i[`ADCT_SCAN_BIT];
        end
    end

    // Channel count frozen in twelve-bit mode; the stored code returns when it ends
    always @(posedge clk_i) begin
        if (rst_i) begin
            channel_count_select_q <= `ADCT_CHCNT_RST;
        end else if (ctrl_hi_wr && !twelve_bit_mode_select_q) begin
            channel_count_select_q <= dat_i[`ADCT_CHCNT_HI:`ADCT_CHCNT_LO];
        end
    end

    // Lower byte: count field, split mode and alternate mux
    always @(posedge clk_i) begin
        if (rst_i) begin
            conversions_per_event_q <= `ADCT_CNT_RST;
            buffer_split_mode_q <= 1'b0;
            alt_q <= 1'b0;
        end else if (ctrl_lo_wr) begin
            conversions_per_event_q <= dat_i[`ADCT_CPE_HI:`ADCT_CPE_LO];
            buffer_split_mode_q <= dat_i[`ADCT_SPLIT_BIT];
            alt_q <= dat_i[`ADCT_ALT_BIT];
        end
    end

    // Any write to the count byte restarts the period; a done in the next cycle is lost
    always @(posedge clk_i) begin
        if (rst_i) begin
            cpe_wr_q <= 1'b0;
        end else begin
            cpe_wr_q <= ctrl_lo_wr;
        end
    end

    // Interrupt mask, same layout as status
    always @(posedge clk_i) begin
        if (rst_i) begin
            mask_q <= `ADCT_ST_RST;
        end else if (mask_wr) begin
            mask_q <= dat_i[`ADCT_ST_DMA:`ADCT_ST_EVT];
        end
    end

    // Mode bits; a mode change keeps the running count, so rewrite the count byte after it
    always @(posedge clk_i) begin
        if (rst_i) begin
            dma_address_mode_enable_q <= 1'b0;
            twelve_bit_mode_select_q <= 1'b0;
        end else if (cfg_wr) begin
            dma_address_mode_enable_q <= dat_i[`ADCT_DMA_BIT];
            twelve_bit_mode_select_q <= dat_i[`ADCT_TWELVE_BIT];
        end
    end

    // ****************************************
    // Conversion counting
    // ****************************************
    // The counter compares for equality, so a limit lowered below the running count
    // lets it run on to the wrap at 31 before the first event; rewriting the count
    // byte after a mode change avoids that long first period
    // Interrupt mode ignores the top bit of the count field
    assign limit = dma_address_mode_enable_q ? conversions_per_event_q
                 : {1'b0, conversions_per_event_q[3:0]};

    adct_evt_count u_cnt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(cpe_wr_q),
        .done_i(conv_done_i),
        .limit_i(limit),
        .hit_o(hit),
        .count_o()
    );

    // Route each terminal count to interrupt or DMA step
    // Registered so the core sees a clean one-cycle pulse; status sets on the same edge
    always @(posedge clk_i) begin
        if (rst_i) begin
            event_irq_pulse_o <= 1'b0;
            dma_step_o <= 1'b0;
        end else begin
            event_irq_pulse_o <= hit && !dma_address_mode_enable_q;
            dma_step_o <= hit && dma_address_mode_enable_q;
        end
    end

    // Buffer half tracking: 1 on upper half, 0 on lower half; held at 0 without split
    // Toggles are ignored while split mode is off, so the core restarts on the lower half
    always @(posedge clk_i) begin
        if (rst_i) begin
            buffer_half_status_q <= 1'b0;
        end else if (!buffer_split_mode_q) begin
            buffer_half_status_q <= 1'b0;
        end else if (half_toggle_i) begin
            buffer_half_status_q <= !buffer_half_status_q;
        end
    end

    // ****************************************
    // Converter steering outputs
    // ****************************************
    // Channel n converts once the count code reaches its group; 10 and 11 mean the same
    genvar g;
    generate
        for (g = 0; g < `ADCT_NUM_CHAN; g = g + 1) begin : g_chan
            if (g == 0) begin : g_base
                // Channel 0 converts in every mode, twelve-bit mode included
                assign chan_want[g] = 1'b1;
            end else if (g == 1) begin : g_pair
                // Channel 1 joins for codes 01 and 1x
                assign chan_want[g] = channel_count_rd[1] || channel_count_rd[0];
            end else begin : g_quad
                // Channels 2 and 3 need code 1x
                assign chan_want[g] = channel_count_rd[1];
            end
        end
    endgenerate

    // Codes 000 and 1xx both fall to supply and ground
    always @(posedge clk_i) begin
        if (rst_i) begin
            ref_ext_high_o <= 1'b0;
            ref_ext_low_o <= 1'b0;
            scan_first_mux_o <= 1'b0;
            chan_enable_o <= `ADCT_CHAN_RST;
            buffer_split_mode_o <= 1'b0;
            alt_mux_o <= 1'b0;
        end else begin
            ref_ext_high_o <= (reference_select_q == `ADCT_REF_EXT_HI) ||
                              (reference_select_q == `ADCT_REF_EXT_BOTH);
            ref_ext_low_o <= (reference_select_q == `ADCT_REF_EXT_LO) ||
                             (reference_select_q == `ADCT_REF_EXT_BOTH);
            scan_first_mux_o <= input_scan_select_q;
            chan_enable_o <= chan_want;
            buffer_split_mode_o <= buffer_split_mode_q;
            alt_mux_o <= alt_q;
        end
    end

    // ****************************************
    // Interrupt status
    // ****************************************
    // Bit 0 is the interrupt event, bit 1 the DMA step
    assign evt = {hit && dma_address_mode_enable_q, hit && !dma_address_mode_enable_q};

    // Write one clears per bit; a same-cycle event wins so nothing is lost
    generate
        for (g = 0; g < `ADCT_NUM_EVT; g = g + 1) begin : g_stat
            assign stat_d[g] = evt[g] || (stat_q[g] && !(stat_clr && dat_i[g]));
        end
    endgenerate

    // One register for both bits keeps a single driver
    always @(posedge clk_i) begin
        if (rst_i) begin
            stat_q <= `ADCT_ST_RST;
        end else begin
            stat_q <= stat_d;
        end
    end

    // Level output: stays high until software clears or masks every pending bit
    assign irq_o = |(stat_q & mask_q);
endmodule
`default_nettype wire

//--- dv/adct_ctrl2_assertions.sv
// Port checker for the second converter control register
`timescale 1ns/10ps
`default_nettype none
module adct_chk (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [3:0] adr_i,
    input wire [31:0] dat_o,
    input wire ack_o,
    input wire err_o,
    input wire conv_done_i,
    input wire ref_ext_high_o,
    input wire ref_ext_low_o,
    input wire scan_first_mux_o,
    input wire [3:0] chan_enable_o,
    input wire buffer_split_mode_o,
    input wire event_irq_pulse_o,
    input wire dma_step_o
);
    // ****
    // Shared timing
    // ****
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // A request the slave has not yet answered
    sequence s_take;
        cyc_i && stb_i && !ack_o && !err_o;
    endsequence
    // Control read answered; outputs must agree with read data
    sequence s_ctrl_rd;
        s_take ##0 (!we_i && adr_i == 4'h0) ##1 ack_o;
    endsequence
    bus_answer_a: assert property (s_take |=> ack_o || err_o)
        else $error("request left unanswered");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack held too long");
    ref_code_a: assert property (s_ctrl_rd |->
        ref_ext_high_o == (dat_o[15:13] == 3'h1 || dat_o[15:13] == 3'h3)
        && ref_ext_low_o == (dat_o[15:13] == 3'h2 || dat_o[15:13] == 3'h3))
        else $error("reference outputs disagree with field");
    scan_bit_a: assert property (s_ctrl_rd |-> scan_first_mux_o == dat_o[10])
        else $error("scan output disagrees with field");
    chan_map_a: assert property (s_ctrl_rd |->
        chan_enable_o == (dat_o[9] ? 4'hf : (dat_o[8] ? 4'h3 : 4'h1)))
        else $error("channel enables disagree with field");
    half_valid_a: assert property (s_ctrl_rd |-> buffer_split_mode_o || !dat_o[7])
        else $error("half status set without split mode");
    evt_cause_a: assert property (event_irq_pulse_o |-> $past(conv_done_i) && !dma_step_o)
        else $error("event pulse without a conversion");
    dma_cause_a: assert property (dma_step_o |-> $past(conv_done_i))
        else $error("address step without a conversion");
endmodule
bind adct_ctrl2 adct_chk chk_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o,
    .ack_o, .err_o, .conv_done_i, .ref_ext_high_o, .ref_ext_low_o, .scan_first_mux_o,
    .chan_enable_o, .buffer_split_mode_o, .event_irq_pulse_o, .dma_step_o);
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench for the second converter control register
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic conv_done_i = 1'b0;
    logic half_toggle_i = 1'b0;
    logic [3:0] adr_i = 4'h0;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] rq;
    logic [31:0] d;
    logic re;
    wire [31:0] dat_o;
    wire [3:0] ch;
    wire ack_o, err_o, rh, rl, sc, sm, am, ev, dm, irq_o;
    int n_errors = 0;
    int n_checks = 0;
    int n_ev = 0;
    int n_dm = 0;
    adct_ctrl2 dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .err_o(err_o), .conv_done_i(conv_done_i),
        .half_toggle_i(half_toggle_i), .ref_ext_high_o(rh), .ref_ext_low_o(rl),
        .scan_first_mux_o(sc), .chan_enable_o(ch), .buffer_split_mode_o(sm),
        .alt_mux_o(am), .event_irq_pulse_o(ev), .dma_step_o(dm), .irq_o(irq_o));
    // ****
    // Clock, pulse tallies and watchdog
    // ****
    initial forever #50 clk_i = ~clk_i;
    // Pulses are one cycle wide, so counting every edge catches each one
    always @(posedge clk_i) begin
        n_ev <= n_ev + ev;
        n_dm <= n_dm + dm;
    end
    // Whole run is a few hundred cycles; this cuts a hang short
    initial begin
        #2000000;
        n_errors++;
        close_out;
    end
    // ****
    // Tasks and expectations
    // ****
    task close_out;
        begin
            $display("checks %0d mismatches %0d", n_checks, n_errors);
            if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            n_checks++;
            if (got !== exp) begin
                n_errors++;
                $display("mismatch at %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // Classic cycle: hold everything until ack or err is sampled high; only the watchdog ends a wait
    task wb(input logic w, input logic [3:0] a, input logic [31:0] dd);
        begin
            cyc_i <= 1'b1;
            stb_i <= 1'b1;
            we_i <= w;
            adr_i <= a;
            dat_i <= dd;
            sel_i <= 4'hf;
            do @(posedge clk_i); while (ack_o !== 1'b1 && err_o !== 1'b1);
            rq = dat_o;
            re = err_o;
            cyc_i <= 1'b0;
            stb_i <= 1'b0;
            @(posedge clk_i);
        end
    endtask
    task done_n(input int k);
        begin
            repeat (k) begin
                conv_done_i <= 1'b1;
                @(posedge clk_i);
                conv_done_i <= 1'b0;
                @(posedge clk_i);
            end
            repeat (2) @(posedge clk_i);
        end
    endtask
    task flip_half;
        begin
            half_toggle_i <= 1'b1;
            @(posedge clk_i);
            half_toggle_i <= 1'b0;
            @(posedge clk_i);
            wb(1'b0, 4'h0, 32'h0);
        end
    endtask
    function logic [3:0] chan_exp(input logic [1:0] c);
        return c[1] ? 4'hf : (c[0] ? 4'h3 : 4'h1);
    endfunction
    // Count test: stale dones before the field write must not count
    task cnt(input logic dma);
        int per, e0, m0;
        begin
            wb(1'b1, 4'hc, {31'h0, dma});
            wb(1'b1, 4'h8, 32'h3);
            d = $urandom & 32'h7c;
            per = dma ? d[6:2] + 1 : d[5:2] + 1;
            done_n(3);
            wb(1'b1, 4'h0, d);
            wb(1'b1, 4'h4, 32'h3);
            e0 = n_ev;
            m0 = n_dm;
            done_n(per - 1);
            chk(n_ev + n_dm - e0 - m0, 0);
            chk(irq_o, 1'b0);
            done_n(1);
            chk(n_ev - e0, !dma);
            chk(n_dm - m0, dma);
            chk(irq_o, 1'b1);
            wb(1'b1, 4'h8, 32'h0);
            chk(irq_o, 1'b0);
            wb(1'b1, 4'h8, 32'h3);
            wb(1'b1, 4'h4, 32'h3);
            chk(irq_o, 1'b0);
            $display("count test done, period %0d", per);
        end
    endtask
    // ****
    // Main sequence
    // ****
    initial begin
        void'($urandom(32'h6f7c164b));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, 4'h0, 32'h0);
        chk(rq, 32'h0);
        chk(ch, 4'h1);
        // Every reference code with random neighbours; bit 7 and 12:11 read 0
        for (int i = 0; i < 8; i++) begin
            d = ($urandom & 32'h1ffd) | (i << 13);
            wb(1'b1, 4'h0, d);
            wb(1'b0, 4'h0, 32'h0);
            chk(rq, d & 32'he77f);
            chk({rh, rl}, {i[2:0] == 3'h1 || i[2:0] == 3'h3, i[2:1] == 2'h1});
            chk(sc, d[10]);
            chk(ch, chan_exp(d[9:8]));
            chk({sm, am}, {1'b0, d[0]});
        end
        $display("field test done");
        wb(1'b1, 4'hc, 32'h2);
        wb(1'b1, 4'h0, 32'h300);
        wb(1'b0, 4'h0, 32'h0);
        chk(rq[9:8], 2'h0);
        chk(ch, 4'h1);
        wb(1'b1, 4'h0, 32'h2);
        chk(sm, 1'b1);
        flip_half;
        chk(rq[7], 1'b1);
        flip_half;
        chk(rq[7], 1'b0);
        wb(1'b0, 4'h2, 32'h0);
        chk(re, 1'b1);
        chk(rq, 32'h0);
        $display("mode test done");
        for (int k = 0; k < 4; k++) cnt(k[0]);
        close_out;
    end
endmodule
`default_nettype wire
